/* File: hdl/rfm_map.svh */
// register offsets, field positions, reset values and timing counts of the rf timing bank
`ifndef RFM_MAP_SVH
`define RFM_MAP_SVH

`define RFM_ADDR_SQUELCH 8'h0F
`define RFM_ADDR_GUARD 8'h15
`define RFM_ADDR_MAIN_MASK 8'h16
`define RFM_ADDR_TIMER_MASK 8'h17
`define RFM_ADDR_ERROR_MASK 8'h18
`define RFM_ADDR_TARGET_MASK 8'h19
`define RFM_ADDR_MAIN_STS 8'h1A
`define RFM_ADDR_TIMER_STS 8'h1B
`define RFM_ADDR_ERROR_STS 8'h1C
`define RFM_ADDR_TARGET_STS 8'h1D
`define RFM_ADDR_PEER_WAIT 8'h30
`define RFM_ADDR_MRT 8'h31
`define RFM_ADDR_TIMER_CTRL 8'h32
`define RFM_ADDR_ENGINE_STS 8'h33

`define RFM_RST_PEER_WAIT 8'h80
`define RFM_RST_GUARD 8'h33
`define RFM_RST_ZERO 8'h00

`define RFM_MRT_STEP_BIT 3
`define RFM_TMR_GUARD_BIT 1
`define RFM_TGT_PEER_BIT 7
`define RFM_MAIN_VALID 8'hFE
`define RFM_TIMER_VALID 8'hFF
`define RFM_ERROR_VALID 8'hFF
`define RFM_TARGET_VALID 8'hFB
`define RFM_SQ_MIN_VALUE 8'h05

`define RFM_MRT_STEP_FINE 64
`define RFM_MRT_STEP_COARSE 512
`define RFM_PEER_STEP 64
`define RFM_GUARD_STEP 2048

`define RFM_CLK_PERIOD_NS 40
`define RFM_SQ_DELAY_NS 20000
`define RFM_GUARD_BASE_NS 75000
`define RFM_SQ_DELAY_CYC ((`RFM_SQ_DELAY_NS + `RFM_CLK_PERIOD_NS - 1) / `RFM_CLK_PERIOD_NS)
`define RFM_GUARD_BASE_CYC ((`RFM_GUARD_BASE_NS + `RFM_CLK_PERIOD_NS - 1) / `RFM_CLK_PERIOD_NS)

`endif

/* File: hdl/rfm_pkg.sv */
// types shared by the rf timing bank
`default_nettype none
package rfm_pkg;
  typedef enum logic [1:0] {
    SQ_IDLE = 2'b00,
    SQ_WAIT = 2'b01,
    SQ_ON = 2'b11,
    SQ_HOLD = 2'b10
  } rfm_sq_state_type;
endpackage
`default_nettype wire

/* File: hdl/rfm_step_timer.sv */
// down counter of value times step ticks, one done pulse at expiry
`default_nettype none
module rfm_step_timer #(
  parameter int VW = 8,
  parameter int SW = 12
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic start,
  input wire logic abort,
  input wire logic tick,
  input wire logic [VW-1:0] value,
  input wire logic [SW-1:0] step,
  output logic busy,
  output logic done
);
  logic [VW-1:0] steps_r;
  logic [SW-1:0] pre_r;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      busy <= 1'b0;
      done <= 1'b0;
      steps_r <= '0;
      pre_r <= '0;
    end else if (start) begin
      // zero value expires at once
      busy <= (value != '0);
      done <= (value == '0);
      steps_r <= value;
      pre_r <= step - 1'b1;
    end else if (abort) begin
      busy <= 1'b0;
      done <= 1'b0;
    end else if (busy && tick) begin
      if (pre_r == '0) begin
        pre_r <= step - 1'b1;
        steps_r <= steps_r - 1'b1;
        busy <= (steps_r != 1);
        done <= (steps_r == 1);
      end else begin
        pre_r <= pre_r - 1'b1;
        done <= 1'b0;
      end
    end else begin
      done <= 1'b0;
    end
  end
endmodule
`default_nettype wire

/* File: hdl/rfm_regs.sv */
// rf timing and interrupt mask register bank with its timers
`include "rfm_map.svh"
`default_nettype none
// Operation
// - the peer field wait timer waits up to the 8-bit value times 64 carrier periods.
// - squelch turns on about 20 us after the end of reader transmission.
// - a squelch value above 5 and below the mask receive value ends squelch after that time and freezes the gain for the agc.
// - a squelch value of 5 or less, or not below the mask receive value, holds squelch to mrt end.
// - field-on commands time the guard with the 8-bit value in steps of 2048 carrier periods.
// - the guard interval is a fixed 75 us plus the programmed guard time.
// - main mask bits 7 to 1 suppress their sources, bit 0 is unused.
// - timer mask bits 7 to 0 suppress command, no-response, timer, field and guard sources.
// - error mask bits 7 to 0 suppress crc, parity, framing and wake-up sources.
// - target mask bits suppress target sources, bit 2 is reserved.
// - reading a status register clears it to zero, except for bits of events arriving in the same cycle.
// - the mask receive timer steps by 64 or 512 carrier periods chosen by one bit.
module rfm_regs (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  input wire logic fc_tick,
  input wire logic tx_end,
  input wire logic field_on_cmd,
  input wire logic peer_wait_start,
  input wire logic peer_field_on,
  input wire logic [7:0] main_evt,
  input wire logic [7:0] timer_evt,
  input wire logic [7:0] error_evt,
  input wire logic [7:0] target_evt,
  output logic squelch_on,
  output logic gain_freeze,
  output logic mrt_active,
  output logic guard_active,
  output logic peer_wait_active,
  output logic irq
);
  logic [7:0] squelch_duration_r;
  logic [7:0] field_guard_count_r;
  logic [7:0] peer_field_wait_r;
  logic [7:0] mrt_value_r;
  logic mrt_step_r;
  logic [7:0] mask_r [4];
  logic [7:0] sts_r [4];
  logic [7:0] sts_nxt [4];
  logic [7:0] ev [4];
  logic [7:0] valid [4];
  logic [7:0] rdata_nxt;
  logic irq_nxt;
  rfm_pkg::rfm_sq_state_type sq_state_r;
  rfm_pkg::rfm_sq_state_type sq_state_nxt;
  logic sq_early_r;
  logic [11:0] mrt_step;
  logic mrt_busy;
  logic sqt_busy;
  logic sqd_done;
  logic gpre_busy;
  logic gpre_done;
  logic grd_busy;
  logic grd_done;
  logic peer_busy;
  logic peer_done;

  assign valid[0] = `RFM_MAIN_VALID;
  assign valid[1] = `RFM_TIMER_VALID;
  assign valid[2] = `RFM_ERROR_VALID;
  assign valid[3] = `RFM_TARGET_VALID;
  // masks and status each sit on four consecutive offsets, indexed by group

  // configuration registers
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      squelch_duration_r <= `RFM_RST_ZERO;
      field_guard_count_r <= `RFM_RST_GUARD;
      peer_field_wait_r <= `RFM_RST_PEER_WAIT;
      mrt_value_r <= `RFM_RST_ZERO;
      mrt_step_r <= 1'b0;
    end else if (wr) begin
      if (addr == `RFM_ADDR_SQUELCH) begin
        squelch_duration_r <= wdata;
      end else if (addr == `RFM_ADDR_GUARD) begin
        field_guard_count_r <= wdata;
      end else if (addr == `RFM_ADDR_PEER_WAIT) begin
        peer_field_wait_r <= wdata;
      end else if (addr == `RFM_ADDR_MRT) begin
        mrt_value_r <= wdata;
      end else if (addr == `RFM_ADDR_TIMER_CTRL) begin
        mrt_step_r <= wdata[`RFM_MRT_STEP_BIT];
      end
    end
  end

  // mask registers
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int g = 0; g < 4; g++) begin
        mask_r[g] <= `RFM_RST_ZERO;
      end
    end else if (wr) begin
      for (int g = 0; g < 4; g++) begin
        if (addr == `RFM_ADDR_MAIN_MASK + 8'(g)) begin
          mask_r[g] <= wdata;
        end
      end
    end
  end

  // status: new events win over a read or write-one clear in the same cycle
  always_comb begin
    ev[0] = main_evt;
    ev[1] = timer_evt;
    ev[2] = error_evt;
    ev[3] = target_evt;
    ev[1][`RFM_TMR_GUARD_BIT] = timer_evt[`RFM_TMR_GUARD_BIT] | grd_done;
    ev[3][`RFM_TGT_PEER_BIT] = target_evt[`RFM_TGT_PEER_BIT] | peer_done;
    for (int g = 0; g < 4; g++) begin
      if (rd && addr == `RFM_ADDR_MAIN_STS + 8'(g)) begin
        sts_nxt[g] = ev[g] & valid[g];
      end else if (wr && addr == `RFM_ADDR_MAIN_STS + 8'(g)) begin
        sts_nxt[g] = ((sts_r[g] & ~wdata) | ev[g]) & valid[g];
      end else begin
        sts_nxt[g] = (sts_r[g] | ev[g]) & valid[g];
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int g = 0; g < 4; g++) begin
        sts_r[g] <= `RFM_RST_ZERO;
      end
    end else begin
      for (int g = 0; g < 4; g++) begin
        sts_r[g] <= sts_nxt[g];
      end
    end
  end

  // interrupt follows status one cycle after an event, two cycles after a mask write
  always_comb begin
    irq_nxt = 1'b0;
    for (int g = 0; g < 4; g++) begin
      irq_nxt = irq_nxt | (|(sts_nxt[g] & ~mask_r[g]));
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      irq <= 1'b0;
    end else begin
      irq <= irq_nxt;
    end
  end

  // read mux, data valid only in the cycle after the strobe
  always_comb begin
    rdata_nxt = 8'h00;
    if (addr == `RFM_ADDR_SQUELCH) begin
      rdata_nxt = squelch_duration_r;
    end else if (addr == `RFM_ADDR_GUARD) begin
      rdata_nxt = field_guard_count_r;
    end else if (addr == `RFM_ADDR_PEER_WAIT) begin
      rdata_nxt = peer_field_wait_r;
    end else if (addr == `RFM_ADDR_MRT) begin
      rdata_nxt = mrt_value_r;
    end else if (addr == `RFM_ADDR_TIMER_CTRL) begin
      rdata_nxt[`RFM_MRT_STEP_BIT] = mrt_step_r;
    end else if (addr == `RFM_ADDR_ENGINE_STS) begin
      rdata_nxt = {3'h0, peer_busy, grd_busy | gpre_busy, mrt_busy, gain_freeze, squelch_on};
    end
    for (int g = 0; g < 4; g++) begin
      if (addr == `RFM_ADDR_MAIN_MASK + 8'(g)) begin
        rdata_nxt = mask_r[g];
      end else if (addr == `RFM_ADDR_MAIN_STS + 8'(g)) begin
        rdata_nxt = sts_r[g];
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rdata <= 8'h00;
    end else begin
      rdata <= rd ? rdata_nxt : 8'h00;
    end
  end

  // mask receive timer and squelch duration share one step
  assign mrt_step = mrt_step_r ? 12'(`RFM_MRT_STEP_COARSE) : 12'(`RFM_MRT_STEP_FINE);

  rfm_step_timer #(.VW(8), .SW(12)) u_mrt (
    .clk(clk),
    .reset_n(reset_n),
    .start(tx_end),
    .abort(1'b0),
    .tick(fc_tick),
    .value(mrt_value_r),
    .step(mrt_step),
    .busy(mrt_busy),
    .done()
  );

  rfm_step_timer #(.VW(8), .SW(12)) u_sqt (
    .clk(clk),
    .reset_n(reset_n),
    .start(tx_end),
    .abort(1'b0),
    .tick(fc_tick),
    .value(squelch_duration_r),
    .step(mrt_step),
    .busy(sqt_busy),
    .done()
  );

  // enable delay counted on the system clock
  rfm_step_timer #(.VW(1), .SW(12)) u_sq_delay (
    .clk(clk),
    .reset_n(reset_n),
    .start(tx_end),
    .abort(1'b0),
    .tick(1'b1),
    .value(1'b1),
    .step(12'(`RFM_SQ_DELAY_CYC)),
    .busy(),
    .done(sqd_done)
  );

  // early stop only when the squelch time falls strictly inside the receive mask
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sq_early_r <= 1'b0;
    end else if (tx_end) begin
      sq_early_r <= (squelch_duration_r > `RFM_SQ_MIN_VALUE) &&
                    (squelch_duration_r < mrt_value_r);
    end
  end

  always_comb begin
    sq_state_nxt = sq_state_r;
    case (sq_state_r)
      rfm_pkg::SQ_IDLE: begin
        if (tx_end) begin
          sq_state_nxt = rfm_pkg::SQ_WAIT;
        end
      end
      rfm_pkg::SQ_WAIT: begin
        if (tx_end) begin
          sq_state_nxt = rfm_pkg::SQ_WAIT;
        end else if (!mrt_busy) begin
          sq_state_nxt = rfm_pkg::SQ_IDLE;
        end else if (sqd_done) begin
          sq_state_nxt = rfm_pkg::SQ_ON;
        end
      end
      rfm_pkg::SQ_ON: begin
        if (tx_end) begin
          sq_state_nxt = rfm_pkg::SQ_WAIT;
        end else if (!mrt_busy) begin
          sq_state_nxt = rfm_pkg::SQ_IDLE;
        end else if (sq_early_r && !sqt_busy) begin
          sq_state_nxt = rfm_pkg::SQ_HOLD;
        end
      end
      rfm_pkg::SQ_HOLD: begin
        if (tx_end) begin
          sq_state_nxt = rfm_pkg::SQ_WAIT;
        end else if (!mrt_busy) begin
          sq_state_nxt = rfm_pkg::SQ_IDLE;
        end
      end
      default: begin
        sq_state_nxt = rfm_pkg::SQ_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sq_state_r <= rfm_pkg::SQ_IDLE;
      squelch_on <= 1'b0;
      mrt_active <= 1'b0;
    end else begin
      sq_state_r <= sq_state_nxt;
      squelch_on <= (sq_state_nxt == rfm_pkg::SQ_ON);
      mrt_active <= mrt_busy;
    end
  end

  // frozen gain stays as the agc start point until the next transmission
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      gain_freeze <= 1'b0;
    end else if (tx_end) begin
      gain_freeze <= 1'b0;
    end else if (sq_state_r == rfm_pkg::SQ_ON && sq_state_nxt == rfm_pkg::SQ_HOLD) begin
      gain_freeze <= 1'b1;
    end
  end

  // guard: fixed base first, then the programmed steps
  rfm_step_timer #(.VW(1), .SW(12)) u_guard_base (
    .clk(clk),
    .reset_n(reset_n),
    .start(field_on_cmd),
    .abort(1'b0),
    .tick(1'b1),
    .value(1'b1),
    .step(12'(`RFM_GUARD_BASE_CYC)),
    .busy(gpre_busy),
    .done(gpre_done)
  );

  rfm_step_timer #(.VW(8), .SW(12)) u_guard (
    .clk(clk),
    .reset_n(reset_n),
    .start(gpre_done),
    .abort(field_on_cmd),
    .tick(fc_tick),
    .value(field_guard_count_r),
    .step(12'(`RFM_GUARD_STEP)),
    .busy(grd_busy),
    .done(grd_done)
  );

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      guard_active <= 1'b0;
    end else if (field_on_cmd) begin
      guard_active <= 1'b1;
    end else if (grd_done) begin
      guard_active <= 1'b0;
    end
  end

  // peer wait ends quietly when the peer field shows up
  rfm_step_timer #(.VW(8), .SW(12)) u_peer (
    .clk(clk),
    .reset_n(reset_n),
    .start(peer_wait_start),
    .abort(peer_field_on),
    .tick(fc_tick),
    .value(peer_field_wait_r),
    .step(12'(`RFM_PEER_STEP)),
    .busy(peer_busy),
    .done(peer_done)
  );

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      peer_wait_active <= 1'b0;
    end else if (peer_wait_start) begin
      peer_wait_active <= 1'b1;
    end else if (peer_field_on || peer_done) begin
      peer_wait_active <= 1'b0;
    end
  end
endmodule
`default_nettype wire

/* File: bench/rfm_regs_chk.sv */
// port assertions for the rf timing and mask bank
`default_nettype none
module rfm_regs_chk (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [7:0] rdata,
  input wire logic tx_end,
  input wire logic [7:0] main_evt,
  input wire logic squelch_on,
  input wire logic gain_freeze,
  input wire logic mrt_active,
  input wire logic guard_active,
  input wire logic irq
);
  logic [7:0] mask_r;
  logic [11:0] gcnt_r;
  logic [11:0] scnt_r;
  always_ff @(posedge clk or negedge reset_n)
    if (!reset_n) mask_r <= 8'h00;
    else if (wr && addr == 8'h16) mask_r <= wdata;
  always_ff @(posedge clk or negedge reset_n)
    if (!reset_n) gcnt_r <= 12'h000;
    else gcnt_r <= guard_active ? gcnt_r + 12'(gcnt_r != 12'hFFF) : 12'h000;
  // saturates so a long idle never aliases into the start window
  always_ff @(posedge clk or negedge reset_n)
    if (!reset_n) scnt_r <= 12'hFFF;
    else scnt_r <= tx_end ? 12'h001 : scnt_r + 12'(scnt_r != 12'hFFF);
  default clocking @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  chk_main_rsvd: assert property (rd && addr == 8'h1A |=> !rdata[0])
    else $error("main status bit 0 read as one");
  chk_target_rsvd: assert property (rd && addr == 8'h1D |=> !rdata[2])
    else $error("target status bit 2 read as one");
  chk_status_clear: assert property ((rd && addr == 8'h1A && main_evt == 8'h00) ##1
    (rd && addr == 8'h1A && main_evt == 8'h00) |=> rdata == 8'h00)
    else $error("main status not cleared by read");
  chk_irq_raise: assert property ((main_evt & ~mask_r & 8'hFE) != 8'h00 && !wr |=> irq)
    else $error("unmasked event left irq low");
  chk_masked_kept: assert property ((main_evt[7] && !wr) ##1 (!wr && !rd)
    ##1 (rd && addr == 8'h1A) |=> rdata[7])
    else $error("event lost from main status");
  chk_guard_min: assert property ($fell(guard_active) |-> gcnt_r >= 12'd1874)
    else $error("guard interval shorter than base");
  chk_squelch_delay: assert property ($rose(squelch_on) |-> scnt_r inside {[500:502]})
    else $error("squelch start delay wrong");
  chk_freeze_stop: assert property ($rose(gain_freeze) |-> $fell(squelch_on))
    else $error("gain frozen without squelch stop");
  chk_squelch_mrt: assert property (squelch_on |-> mrt_active)
    else $error("squelch outside mask receive time");
endmodule
bind rfm_regs rfm_regs_chk rfm_regs_chk_i (.clk, .reset_n, .addr, .wdata, .wr, .rd, .rdata,
  .tx_end, .main_evt, .squelch_on, .gain_freeze, .mrt_active, .guard_active, .irq);
`default_nettype wire

/* File: bench/test_rfm_regs.sv */
// self-checking bench for the rf timing and mask bank
`default_nettype none
module test_rfm_regs;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic fc_tick = 1'b0;
  logic tx_end = 1'b0;
  logic field_on_cmd = 1'b0;
  logic peer_wait_start = 1'b0;
  logic peer_field_on = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic [7:0] main_evt = 8'h00;
  logic [7:0] timer_evt = 8'h00;
  logic [7:0] error_evt = 8'h00;
  logic [7:0] target_evt = 8'h00;
  logic [7:0] rdata;
  logic squelch_on, gain_freeze, mrt_active, guard_active, peer_wait_active, irq;
  int bad_count = 0;
  int cmp_count = 0;
  int c1;
  int c2;
  logic [7:0] vm [4] = '{8'hFE, 8'hFF, 8'hFF, 8'hFB};
  // step select, mask receive value, squelch value, cycles to squelch end, freeze
  int sq [5][5] = '{'{0, 20, 10, 1280, 1}, '{0, 20, 6, 768, 1}, '{0, 20, 5, 2560, 0},
    '{0, 20, 25, 2560, 0}, '{1, 3, 2, 3072, 0}};
  always #20 clk = ~clk;
  // tick every other cycle so a timer counting clocks instead of ticks shows
  always @(posedge clk) fc_tick <= ~fc_tick;
  rfm_regs rfm_regs_i (.clk, .reset_n, .addr, .wdata, .wr, .rd, .rdata, .fc_tick, .tx_end,
    .field_on_cmd, .peer_wait_start, .peer_field_on, .main_evt, .timer_evt, .error_evt,
    .target_evt, .squelch_on, .gain_freeze, .mrt_active, .guard_active, .peer_wait_active, .irq);
  task automatic check(input string w, input logic [15:0] s, input logic [15:0] e);
    cmp_count++;
    if (s !== e) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", w, e, s);
    end
  endtask
  task automatic cnear(input string w, input int v, input int e);
    check(w, (v >= e - 4 && v <= e + 4) ? 16'(e) : 16'(v), 16'(e));
  endtask
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(negedge clk);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] e, input string w);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    check(w, 16'(rdata), 16'(e));
  endtask
  task automatic drv(input int s, input logic [7:0] v);
    case (s)
      0: main_evt <= v;
      1: timer_evt <= v;
      2: error_evt <= v;
      3: target_evt <= v;
      4: tx_end <= v[0];
      5: field_on_cmd <= v[0];
      6: peer_wait_start <= v[0];
      default: peer_field_on <= v[0];
    endcase
  endtask
  task automatic pls(input int s, input logic [7:0] v);
    @(posedge clk);
    drv(s, v);
    @(posedge clk);
    drv(s, 8'h00);
    @(negedge clk);
  endtask
  function automatic logic sig(input int s);
    case (s)
      0: return squelch_on;
      1: return mrt_active;
      2: return guard_active;
      default: return peer_wait_active;
    endcase
  endfunction
  // bounded wait; c is the number of cycles it took
  task automatic wt(input int s, input logic v, input int n, output int c);
    c = 0;
    while (sig(s) !== v && c < n) begin
      @(negedge clk);
      c++;
    end
    if (sig(s) !== v) begin
      bad_count++;
      $display("[ERR] wait %0d expected %b seen timeout", s, v);
      test_done();
    end
  endtask
  initial begin
    logic [7:0] m;
    logic [7:0] ma;
    logic [7:0] sa;
    repeat (12) @(posedge clk);
    reset_n <= 1'b1;
    rdc(8'h0F, 8'h00, "squelch reset");
    rdc(8'h15, 8'h33, "guard reset");
    rdc(8'h30, 8'h80, "peer reset");
    wreg(8'h40, 8'hFF);
    rdc(8'h40, 8'h00, "unmapped");
    for (int g = 0; g < 4; g++) begin
      ma = 8'h16 + 8'(g);
      sa = 8'h1A + 8'(g);
      rdc(ma, 8'h00, "mask reset");
      wreg(ma, 8'hFA);
      rdc(ma, 8'hFA, "mask rw");
      for (int b = 0; b < 8; b++) begin
        m = 8'h01 << b;
        wreg(ma, 8'hFF);
        pls(g, m);
        check("irq masked", 16'(irq), 16'h0000);
        rdc(sa, m & vm[g], "status");
        rdc(sa, 8'h00, "status cleared");
        wreg(ma, ~m);
        pls(g, m);
        check("irq", 16'(irq), 16'(|(m & vm[g])));
        wreg(sa, m);
        check("irq cleared", 16'(irq), 16'h0000);
      end
      wreg(ma, 8'h00);
    end
    pls(0, 8'h08);
    // two back-to-back reads: the second sees the clear made by the first
    @(posedge clk);
    addr <= 8'h1A;
    rd <= 1'b1;
    @(posedge clk);
    @(negedge clk);
    check("first read", 16'(rdata), 16'h0008);
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    check("second read", 16'(rdata), 16'h0000);
    for (int i = 0; i < 2; i++) begin
      wreg(8'h15, 8'(i));
      pls(5, 8'h01);
      wt(2, 1'b1, 4, c2);
      wt(2, 1'b0, 7000, c1);
      cnear("guard time", c1, 1875 + 4096 * i);
      rdc(8'h1B, 8'h02, "guard expiry");
    end
    wreg(8'h30, 8'h02);
    pls(6, 8'h01);
    wt(3, 1'b1, 4, c2);
    rdc(8'h33, 8'h10, "engine status");
    wt(3, 1'b0, 400, c1);
    cnear("peer wait", c1, 256);
    rdc(8'h1D, 8'h80, "peer timeout");
    pls(6, 8'h01);
    wt(3, 1'b1, 4, c2);
    pls(7, 8'h01);
    wt(3, 1'b0, 4, c1);
    rdc(8'h1D, 8'h00, "peer abort");
    for (int i = 0; i < 5; i++) begin
      wreg(8'h32, {4'h0, sq[i][0][0], 3'h0});
      wreg(8'h31, 8'(sq[i][1]));
      wreg(8'h0F, 8'(sq[i][2]));
      pls(4, 8'h01);
      wt(0, 1'b1, 600, c1);
      cnear("squelch start", c1, 501);
      wt(0, 1'b0, 4000, c2);
      cnear("squelch end", c1 + c2, sq[i][3]);
      check("gain freeze", 16'(gain_freeze), 16'(sq[i][4]));
      wt(1, 1'b0, 4000, c2);
    end
    rdc(8'h32, 8'h08, "mrt step");
    rdc(8'h31, 8'h03, "mrt value");
    test_done();
  end
endmodule
`default_nettype wire
